// ==== converter_control.sv ====
// Converter control and register logic: APB slave, sample timing, result and compare.
// Assumes the analog core presents a 12-bit code and reference-limit flags on pclk.
//
// Contract
// - Deep stop disables converter; all registers return to reset values.
// - Config fields: low power 7, divider 6:5, long sample 4, mode 3:2, source 1:0.
// - Divider 00 undivided, mode 10 is 10-bit, source 00 is bus clock.
// - Control two: active flag 7, trigger 6, compare enable 5, direction 4.
// - Control two bits 3:2 read zero; software writes zero to bits 1:0.
// - Control one bit 7 is read-only complete flag set at conversion end.
// - Control one bit 6 interrupt enable, bit 5 continuous versus single.
// - Control one bits 4:0 select the input channel in binary.
// - High byte read locks result until low byte read; no overwrite meanwhile.
// - Compare value registers feed the automatic compare when enabled.
// - Set pin-control bit disables digital I/O of matching pin.
// - Conversions allowed regardless of pin bit; set bit tri-states and drops pull-up.
// - Input at or above high reference gives full scale for the mode.
// - Input at or below low reference gives zero in every mode.
// - Sample window 3.5 or 23.5 conversion-clock cycles by long sample select; the code rounds up to 4 or 24 when the conversion clock is pclk.
// - Complete flag with interrupt enable raises the interrupt request.
// - Direction 1 needs result at least compare; direction 0 needs result below.
// - Failed compare leaves flag clear and result registers unchanged.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/100ps

module converter_control
(
  input  wire logic        pclk,            // Bus clock, 125 MHz
  input  wire logic        presetn,         // Async reset, active low
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB access phase
  input  wire logic        pwrite,          // APB direction
  input  wire logic [7:0]  paddr,           // APB byte address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // Unmapped address
  input  wire logic        deep_stop,       // Deep stop mode active
  input  wire logic        hw_trigger,      // Hardware trigger pulse
  input  wire logic [11:0] analog_code,     // Raw 12-bit code from the core
  input  wire logic        above_high_ref,  // Input at or above high reference
  input  wire logic        below_low_ref,   // Input at or below low reference
  output logic             irq,             // Conversion complete interrupt
  output logic             sample_enable,   // Sampling switch closed
  output logic      [4:0]  sample_channel,  // Channel routed to the core
  output logic             low_power,       // Low-power bias select
  output logic      [15:0] pin_io_disable   // Digital I/O off per analog pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  converter_config;
  logic [7:0]  control_two;
  logic        complete_flag;
  logic        irq_enable;
  logic        continuous;
  logic [4:0]  channel_select;
  logic [11:0] result;
  logic [11:0] compare_value;
  logic [7:0]  pin_control_first;
  logic [7:0]  pin_control_second;
  logic        result_locked;
  converter_pkg::conv_state_t state;
  logic [9:0]  count;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: a transfer completes at the edge where pready is high
  wire access    = psel & penable & pready;
  wire wr        = access & pwrite;
  wire rd        = access & ~pwrite;
  wire wr_config = wr & (paddr == converter_pkg::addr_config);
  wire wr_two    = wr & (paddr == converter_pkg::addr_control_two);
  wire wr_one    = wr & (paddr == converter_pkg::addr_control_one);
  wire wr_cmp_h  = wr & (paddr == converter_pkg::addr_compare_high);
  wire wr_cmp_l  = wr & (paddr == converter_pkg::addr_compare_low);
  wire wr_pin1   = wr & (paddr == converter_pkg::addr_pin_first);
  wire wr_pin2   = wr & (paddr == converter_pkg::addr_pin_second);
  wire rd_res_h  = rd & (paddr == converter_pkg::addr_result_high);
  wire rd_res_l  = rd & (paddr == converter_pkg::addr_result_low);
  wire mapped    = (paddr <= converter_pkg::addr_pin_second) & (paddr[1:0] == 2'h0);

  // Field views
  wire [1:0] divider     = converter_config[converter_pkg::cfg_divider_lsb +: 2];
  wire       long_sample = converter_config[converter_pkg::cfg_long_sample_bit];
  wire [1:0] mode        = converter_config[converter_pkg::cfg_mode_lsb +: 2];
  wire [1:0] source      = converter_config[converter_pkg::cfg_source_lsb +: 2];
  wire       trig_hw     = control_two[converter_pkg::two_trigger_bit];
  wire       cmp_enable  = control_two[converter_pkg::two_cmp_enable_bit];
  wire       cmp_dir     = control_two[converter_pkg::two_cmp_dir_bit];
  wire       active      = (state != converter_pkg::st_idle);

  // Read mux; control two low nibble is never stored so it reads zero
  wire [7:0] two_view = {active, control_two[6:4], 4'h0};
  wire [7:0] one_view = {complete_flag, irq_enable, continuous, channel_select};
  logic [31:0] rd_mux;
  always_comb
  begin
    case (paddr)
      converter_pkg::addr_config:       rd_mux = {24'h0, converter_config};
      converter_pkg::addr_control_two:  rd_mux = {24'h0, two_view};
      converter_pkg::addr_control_one:  rd_mux = {24'h0, one_view};
      converter_pkg::addr_result_high:  rd_mux = {28'h0, result[11:8]};
      converter_pkg::addr_result_low:   rd_mux = {24'h0, result[7:0]};
      converter_pkg::addr_compare_high: rd_mux = {28'h0, compare_value[11:8]};
      converter_pkg::addr_compare_low:  rd_mux = {24'h0, compare_value[7:0]};
      converter_pkg::addr_pin_first:    rd_mux = {24'h0, pin_control_first};
      converter_pkg::addr_pin_second:   rd_mux = {24'h0, pin_control_second};
      default:                          rd_mux = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock timing: its period in pclk cycles; source 01 halves the bus clock
  wire [4:0] period_shift = {3'h0, divider} + ((source == converter_pkg::source_bus_half) ? 5'h1 : 5'h0);
  wire [9:0] period       = 10'h1 << period_shift;
  wire [5:0] halves       = long_sample ? converter_pkg::long_sample_halves
                                        : converter_pkg::short_sample_halves;
  // Half-cycle windows round up to whole pclk cycles
  wire [15:0] half_prod   = 16'(halves) * 16'(period);
  wire [9:0] sample_len   = 10'((half_prod + 16'h1) >> 1);
  wire [5:0] conv_conversion_clock    = (mode == converter_pkg::mode_8bit) ? converter_pkg::conv_cycles_8bit
                                                               : converter_pkg::conv_cycles_wide;
  wire [15:0] conv_prod   = 16'(conv_conversion_clock) * 16'(period);
  wire [9:0] conv_len     = conv_prod[9:0];

  // Starts: a software-trigger write to control one restarts, even mid-conversion
  wire [4:0] new_channel  = pwdata[4:0];
  wire sw_start  = wr_one & ~trig_hw & (new_channel != converter_pkg::channel_disabled);
  wire hw_start  = hw_trigger & trig_hw & ~active & (channel_select != converter_pkg::channel_disabled);
  wire sample_end = (state == converter_pkg::st_sample) & (count == sample_len - 10'h1);
  wire done       = (state == converter_pkg::st_convert) & (count == conv_len - 10'h1);

  // Result shaping: scale to the mode, then clamp at the references to that mode's full scale or zero
  wire [11:0] full_scale = (mode == converter_pkg::mode_12bit) ? converter_pkg::full_12bit :
                           (mode == converter_pkg::mode_10bit) ? converter_pkg::full_10bit :
                                                                 converter_pkg::full_8bit;
  wire [11:0] scaled     = (mode == converter_pkg::mode_12bit) ? analog_code :
                           (mode == converter_pkg::mode_10bit) ? {2'h0, analog_code[11:2]} :
                                                                 {4'h0, analog_code[11:4]};
  wire [11:0] raw_code   = above_high_ref ? full_scale :
                           below_low_ref  ? 12'h000 : scaled;
  // Compare: the stored value is result minus compare value, as the adder leaves it
  wire        at_least   = (raw_code >= compare_value);
  wire        cmp_pass   = cmp_dir ? at_least : ~at_least;
  wire        accept     = ~cmp_enable | cmp_pass;
  wire [11:0] stored     = cmp_enable ? 12'(raw_code - compare_value) : raw_code;
  // A locked result blocks the transfer; one at either access-phase edge of the high-byte read still lands and can mix a pair
  wire        transfer   = done & accept & ~result_locked;

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait state, ready and data from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers; deep stop forces every one back to reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      converter_config   <= converter_pkg::reset_config;
      control_two        <= converter_pkg::reset_control_two;
      irq_enable         <= 1'b0;
      continuous         <= 1'b0;
      channel_select     <= converter_pkg::channel_disabled;
      compare_value      <= 12'h000;
      pin_control_first  <= converter_pkg::reset_pins;
      pin_control_second <= converter_pkg::reset_pins;
    end
    else if (deep_stop)
    begin
      converter_config   <= converter_pkg::reset_config;
      control_two        <= converter_pkg::reset_control_two;
      irq_enable         <= 1'b0;
      continuous         <= 1'b0;
      channel_select     <= converter_pkg::channel_disabled;
      compare_value      <= 12'h000;
      pin_control_first  <= converter_pkg::reset_pins;
      pin_control_second <= converter_pkg::reset_pins;
    end
    else
    begin
      if (wr_config)
        converter_config <= pwdata[7:0];
      if (wr_two)
        control_two <= {1'b0, pwdata[6:4], 4'h0};
      if (wr_one)
      begin
        irq_enable     <= pwdata[converter_pkg::one_irq_enable_bit];
        continuous     <= pwdata[converter_pkg::one_continuous_bit];
        channel_select <= new_channel;
      end
      if (wr_cmp_h)
        compare_value[11:8] <= pwdata[3:0];
      if (wr_cmp_l)
        compare_value[7:0] <= pwdata[7:0];
      if (wr_pin1)
        pin_control_first <= pwdata[7:0];
      if (wr_pin2)
        pin_control_second <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: sample window, then successive approximation time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= converter_pkg::st_idle;
      count <= 10'h0;
    end
    else if (deep_stop)
    begin
      state <= converter_pkg::st_idle;
      count <= 10'h0;
    end
    else if (sw_start | hw_start)
    begin
      state <= converter_pkg::st_sample;
      count <= 10'h0;
    end
    else
    begin
      case (state)
        converter_pkg::st_sample:
        begin
          count <= sample_end ? 10'h0 : count + 10'h1;
          state <= sample_end ? converter_pkg::st_convert : converter_pkg::st_sample;
        end
        converter_pkg::st_convert:
        begin
          count <= done ? 10'h0 : count + 10'h1;
          if (done)
            state <= continuous ? converter_pkg::st_sample : converter_pkg::st_idle;
        end
        default:
        begin
          count <= 10'h0;
          state <= converter_pkg::st_idle;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result, complete flag and read lock; a completing transfer wins over a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result        <= 12'h000;
      complete_flag <= 1'b0;
      result_locked <= 1'b0;
    end
    else if (deep_stop)
    begin
      result        <= 12'h000;
      complete_flag <= 1'b0;
      result_locked <= 1'b0;
    end
    else
    begin
      if (transfer)
        result <= stored;
      if (transfer)
        complete_flag <= 1'b1;
      else if (wr_one | rd_res_l)
        complete_flag <= 1'b0;
      if (rd_res_h)
        result_locked <= 1'b1;
      else if (rd_res_l | wr_one)
        result_locked <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs toward the core, pins and interrupt controller
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq            <= 1'b0;
      sample_enable  <= 1'b0;
      sample_channel <= converter_pkg::channel_disabled;
      low_power      <= 1'b0;
      pin_io_disable <= 16'h0000;
    end
    else
    begin
      irq            <= complete_flag & irq_enable;
      sample_enable  <= (state == converter_pkg::st_sample);
      sample_channel <= channel_select;
      low_power      <= converter_config[converter_pkg::cfg_low_power_bit];
      pin_io_disable <= {pin_control_second, pin_control_first};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_stop_resets_regs: assert property (@(posedge pclk) disable iff (!presetn)
    deep_stop |=> (converter_config == converter_pkg::reset_config)
    && (channel_select == converter_pkg::channel_disabled) && !active)
    else $error("deep stop did not restore reset values");
  chk_two_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && psel && !pwrite && (paddr == converter_pkg::addr_control_two) |-> (prdata[3:0] == 4'h0))
    else $error("control two low bits read nonzero");
  chk_sample_window: assert property (@(posedge pclk) disable iff (!presetn || deep_stop)
    (state == converter_pkg::st_sample) && $past(state) != converter_pkg::st_sample && !long_sample
    && (period == 10'h1) && !deep_stop && !sw_start |-> ##4 (state == converter_pkg::st_convert))
    else $error("short sample window wrong length");
  chk_irq_on_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(complete_flag) && irq_enable |=> irq)
    else $error("interrupt not raised on completion");
  chk_clamp_high: assert property (@(posedge pclk) disable iff (!presetn)
    done && above_high_ref && !cmp_enable && !result_locked && !deep_stop |=> result == $past(full_scale))
    else $error("full scale clamp wrong");
  chk_clamp_low: assert property (@(posedge pclk) disable iff (!presetn)
    done && below_low_ref && !above_high_ref && !cmp_enable && !result_locked && !deep_stop |=> result == 12'h000)
    else $error("zero clamp wrong");
  chk_compare_fail: assert property (@(posedge pclk) disable iff (!presetn)
    done && cmp_enable && !cmp_pass && !complete_flag && !deep_stop |=> $stable(result) && !complete_flag)
    else $error("failed compare changed result or flag");
  chk_lock_holds: assert property (@(posedge pclk) disable iff (!presetn)
    result_locked && !deep_stop |=> $stable(result))
    else $error("locked result overwritten");
  chk_sw_restart: assert property (@(posedge pclk) disable iff (!presetn)
    sw_start && !deep_stop |=> (state == converter_pkg::st_sample) && (count == 10'h0))
    else $error("software trigger did not restart");

endmodule : converter_control

// ==== converter_pkg.sv ====
// Package for the converter control block: register map, fields, resets, timing.
// Assumes a 32-bit APB with word-aligned registers and a 125 MHz pclk.
package converter_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [7:0] addr_config         = 8'h00;
  localparam logic [7:0] addr_control_two    = 8'h04;
  localparam logic [7:0] addr_control_one    = 8'h08;
  localparam logic [7:0] addr_result_high    = 8'h0c;
  localparam logic [7:0] addr_result_low     = 8'h10;
  localparam logic [7:0] addr_compare_high   = 8'h14;
  localparam logic [7:0] addr_compare_low    = 8'h18;
  localparam logic [7:0] addr_pin_first      = 8'h1c;
  localparam logic [7:0] addr_pin_second     = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int cfg_low_power_bit   = 7;
  localparam int cfg_divider_lsb     = 5;
  localparam int cfg_long_sample_bit = 4;
  localparam int cfg_mode_lsb        = 2;
  localparam int cfg_source_lsb      = 0;
  localparam int two_active_bit      = 7;
  localparam int two_trigger_bit     = 6;
  localparam int two_cmp_enable_bit  = 5;
  localparam int two_cmp_dir_bit     = 4;
  localparam int one_complete_bit    = 7;
  localparam int one_irq_enable_bit  = 6;
  localparam int one_continuous_bit  = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and encodings
  localparam logic [7:0] reset_config      = 8'h00;
  localparam logic [7:0] reset_control_two = 8'h00;
  localparam logic [4:0] channel_disabled  = 5'h1f;
  localparam logic [7:0] reset_pins        = 8'h00;
  localparam logic [1:0] mode_8bit         = 2'h0;
  localparam logic [1:0] mode_12bit        = 2'h1;
  localparam logic [1:0] mode_10bit        = 2'h2;
  localparam logic [1:0] source_bus_half   = 2'h1;
  localparam logic [11:0] full_12bit       = 12'hfff;
  localparam logic [11:0] full_10bit       = 12'h3ff;
  localparam logic [11:0] full_8bit        = 12'h0ff;

  ////////////////////////////////////////////////////////////////////////////
  // Timing in conversion-clock half cycles and whole cycles
  localparam logic [5:0] short_sample_halves = 6'h07;  // 3.5 cycles
  localparam logic [5:0] long_sample_halves  = 6'h2f;  // 23.5 cycles
  localparam logic [5:0] conv_cycles_8bit    = 6'h11;
  localparam logic [5:0] conv_cycles_wide    = 6'h14;

  typedef enum logic [1:0] {st_idle, st_sample, st_convert} conv_state_t;

endpackage : converter_pkg

// ==== tb_adc_control_registers.sv ====
// Testbench for converter_control: APB register access, conversions, clamping, compare and deep stop.
// Assumes the APB slave answers in the second access cycle and a 125 MHz pclk.
`timescale 1ns/100ps

module tb_adc_control_registers;
  logic        pclk, presetn, psel, penable, pwrite, deep_stop, hw_trigger, above_high_ref, below_low_ref;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, irq, sample_enable, low_power, err;
  logic [11:0] analog_code;
  logic [4:0]  sample_channel;
  logic [15:0] pin_io_disable;
  int          num_errors, tests_run, n, i;

  converter_control i_converter_control (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .deep_stop(deep_stop), .hw_trigger(hw_trigger), .analog_code(analog_code), .above_high_ref(above_high_ref),
    .below_low_ref(below_low_ref), .irq(irq), .sample_enable(sample_enable), .sample_channel(sample_channel),
    .low_power(low_power), .pin_io_disable(pin_io_disable));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 8 ns period
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Compare one value and count it
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : chk

  // One APB transfer; the extra edge at the end keeps two transfers from driving psel in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk("pready", 1'b1, pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Read a register and compare its data
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rchk

  // Start a software conversion, measure the sample window, then let conversion finish
  task automatic conv(input logic [7:0] ctl, input int samp);
    apb(1'b1, converter_pkg::addr_control_one, {24'h0, ctl});
    n = 0;
    for (i = 0; i < 100; i++)
    begin
      @(posedge pclk);
      if (sample_enable === 1'b1) n++;
      else if (n > 0) break;
    end
    chk("sample window", samp, n);
    repeat (30) @(posedge pclk);
  endtask : conv

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  logic [7:0]  cv_cfg [6] = '{8'h00, 8'h14, 8'h08, 8'h00, 8'h04, 8'h18};
  logic [13:0] cv_in  [6] = '{{2'b00, 12'hab0}, {2'b10, 12'h000}, {2'b10, 12'h000}, {2'b10, 12'h000},
                              {2'b01, 12'hfff}, {2'b00, 12'habc}};
  logic [15:0] cv_res [6] = '{16'h00ab, 16'h0fff, 16'h03ff, 16'h00ff, 16'h0000, 16'h02af};
  logic [15:0] cp_in  [4] = '{16'h1380, 16'h1080, 16'h0080, 16'h0380};
  logic [16:0] cp_res [4] = '{17'h10280, 17'h00280, 17'h10f80, 17'h00f80};
  initial
  begin
    num_errors = 0; tests_run = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    deep_stop = 1'b0; hw_trigger = 1'b0; analog_code = 12'h0; above_high_ref = 1'b0; below_low_ref = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("channel out", 5'h1f, sample_channel);
    rchk("control one reset", converter_pkg::addr_control_one, 32'h1f);
    rchk("control two", converter_pkg::addr_control_two, 32'h0);
    apb(1'b1, converter_pkg::addr_config, 32'h98);
    rchk("config", converter_pkg::addr_config, 32'h98);
    chk("low power", 1'b1, low_power);
    apb(1'b1, converter_pkg::addr_control_two, 32'hfc);
    rchk("control two fields", converter_pkg::addr_control_two, 32'h70);
    apb(1'b1, converter_pkg::addr_control_two, 32'h0);
    apb(1'b1, converter_pkg::addr_pin_first, 32'h02);
    @(posedge pclk);
    chk("pin disable", 16'h0002, pin_io_disable);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", 1'b1, err);
    chk("unmapped data", 32'h0, rd);
    // Resolution modes, clamping and sample length, each with interrupt enabled on channel 1
    for (int k = 0; k < 6; k++)
    begin
      apb(1'b1, converter_pkg::addr_config, {24'h0, cv_cfg[k]});
      {above_high_ref, below_low_ref, analog_code} <= cv_in[k];
      conv(8'h41, cv_cfg[k][4] ? 24 : 4);
      chk("channel out", 5'h01, sample_channel);
      chk("irq", 1'b1, irq);
      rchk("complete", converter_pkg::addr_control_one, 32'hc1);
      rchk("result high", converter_pkg::addr_result_high, {28'h0, cv_res[k][11:8]});
      rchk("result low", converter_pkg::addr_result_low, {24'h0, cv_res[k][7:0]});
      rchk("complete cleared", converter_pkg::addr_control_one, 32'h41);
    end
    {above_high_ref, below_low_ref} <= 2'b00;
    // Compare in 12-bit mode against 0x100, direction 1 (at least) then direction 0 (below)
    apb(1'b1, converter_pkg::addr_config, 32'h04);
    apb(1'b1, converter_pkg::addr_compare_high, 32'h01);
    apb(1'b1, converter_pkg::addr_compare_low, 32'h00);
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, converter_pkg::addr_control_two, {26'h0, 1'b1, cp_in[k][12], 4'h0});
      analog_code <= cp_in[k][11:0];
      conv(8'h01, 4);
      rchk("compare flag", converter_pkg::addr_control_one, {24'h0, cp_res[k][16], 7'h01});
      if (cp_res[k][16] === 1'b1)
      begin
        rchk("diff high", converter_pkg::addr_result_high, {28'h0, cp_res[k][11:8]});
        rchk("diff low", converter_pkg::addr_result_low, {24'h0, cp_res[k][7:0]});
      end
      else
      begin
        rchk("kept high", converter_pkg::addr_result_high, {28'h0, cp_res[k][11:8]});
        rchk("kept low", converter_pkg::addr_result_low, {24'h0, cp_res[k][7:0]});
      end
    end
    // Continuous mode keeps the converter busy after the first result
    apb(1'b1, converter_pkg::addr_control_two, 32'h0);
    conv(8'h21, 4);
    rchk("continuous active", converter_pkg::addr_control_two, 32'h80);
    rchk("continuous complete", converter_pkg::addr_control_one, 32'ha1);
    // Deep stop returns every register to reset
    deep_stop <= 1'b1;
    repeat (2) @(posedge pclk);
    deep_stop <= 1'b0;
    @(posedge pclk);
    rchk("config stop", converter_pkg::addr_config, 32'h0);
    rchk("control one stop", converter_pkg::addr_control_one, 32'h1f);
    chk("pins stop", 16'h0, pin_io_disable);
    rchk("control two stop", converter_pkg::addr_control_two, 32'h0);
    // After deep stop the whole setup is written again, here with a hardware trigger
    apb(1'b1, converter_pkg::addr_config, 32'h04);
    apb(1'b1, converter_pkg::addr_control_two, 32'h40);
    apb(1'b1, converter_pkg::addr_control_one, 32'h01);
    analog_code <= 12'h5a5;
    rchk("no start on write", converter_pkg::addr_control_two, 32'h40);
    hw_trigger <= 1'b1;
    @(posedge pclk);
    hw_trigger <= 1'b0;
    repeat (40) @(posedge pclk);
    rchk("hw result high", converter_pkg::addr_result_high, 32'h5);
    rchk("hw result low", converter_pkg::addr_result_low, 32'ha5);
    tally_and_finish();
  end
endmodule : tb_adc_control_registers
